// file: include/ppot_consts.svh
// Purpose: constants for the prescaled pulse output timer
// Assumes: 50 MHz system clock
// Notes:   counter width, reset values, source codes, divider end value
`ifndef PPOT_CONSTS_SVH
`define PPOT_CONSTS_SVH
`define PPOT_CNT_W        8
`define PPOT_PRE_RESET    8'hFF
`define PPOT_TMR_RESET    8'hFF
`define PPOT_SRC_F1       3'h0
`define PPOT_SRC_F2       3'h1
`define PPOT_SRC_F8       3'h2
`define PPOT_SRC_OCO      3'h4
`define PPOT_SRC_C32      3'h6
`define PPOT_DIV8_LAST    3'h7
`endif

// file: include/ppot_pkg.sv
// Purpose: types for the prescaled pulse output timer
// Assumes: nothing
// Notes:   io control and software write carriers
package ppot_pkg;
  typedef enum logic [1:0] {
    PPOT_IDLE = 2'b01,
    PPOT_RUN  = 2'b10
  } ppot_state_e;
  typedef struct packed {
    logic start_level;
    logic primary_stop;
    logic secondary_en;
    logic primary_route;
    logic secondary_route;
  } ppot_ioctl_s;
  typedef struct packed {
    logic       pre_we;
    logic       tmr_we;
    logic [7:0] wdata;
  } ppot_wr_s;
endpackage : ppot_pkg

// file: rtl/ppot_src_sel.sv
// Purpose: count source tick generator and selector
// Assumes: oscillator and 32k ticks arrive as one-cycle enables
// Notes:   f2 and f8 are dividers of the system clock
`timescale 1ns/1ns
`include "ppot_consts.svh"
module ppot_src_sel (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  // selection and external ticks
  input  wire logic [2:0] SRC_SEL,
  input  wire logic       OCO_TICK,
  input  wire logic       C32_TICK,
  // selected tick
  output logic            TICK
);
  logic [2:0] div;
  wire        tick_f2 = div[0];
  wire        tick_f8 = (div == `PPOT_DIV8_LAST);
  always_ff @(posedge CLK) begin
    if (!RST_N) div <= 3'h0;
    else        div <= div + 3'h1;
  end
  // selection of five sources [R01]
  assign TICK = (SRC_SEL == `PPOT_SRC_F1)  ? 1'b1 :
                (SRC_SEL == `PPOT_SRC_F2)  ? tick_f2 :
                (SRC_SEL == `PPOT_SRC_F8)  ? tick_f8 :
                (SRC_SEL == `PPOT_SRC_OCO) ? OCO_TICK :
                (SRC_SEL == `PPOT_SRC_C32) ? C32_TICK : 1'b0;
endmodule : ppot_src_sel

// file: rtl/ppot_timer.sv
// Purpose: pulse output mode of an 8-bit prescaler and 8-bit timer
// Assumes: software strobes are one-cycle pulses synchronous to CLK
// Notes:   pins are split into out, enable and input
// Functional notes
// [R01] five selectable internal count sources
// [R02] both stages down-count, reload on underflow
// [R03] underflow rate source divided by (n+1)(m+1)
// [R04] writing start bit one begins counting
// [R05] start zero or forced stop halts
// [R06] each timer underflow raises interrupt
// [R07] primary pin toggles on timer underflow
// [R08] reads return live counter values
// [R09] stopped write loads reload and counter
// [R10] running write targets reload and counter
// [R11] running transfer on tick or prescaler underflow
// [R12] prescaler on source, timer on prescaler underflow
// [R13] polarity bit selects starting output level
// [R14] secondary pin drives inverse when enabled
// [R15] secondary routed to P3_0 or P3_7
// [R16] stop bit halts primary pulse output
// [R17] primary routed to P1_7 or P1_5
// [R18] mode write resets output to start level
// [R19] primary is pulse, port or interrupt input
// [R20] toggle and interrupt in underflow cycle
`timescale 1ns/1ns
`include "ppot_consts.svh"
module ppot_timer #(
  parameter int CNT_W = `PPOT_CNT_W
) (
  // clock and reset
  input  wire logic               CLK,
  input  wire logic               RST_N,
  // count source
  input  wire logic [2:0]         SRC_SEL,
  input  wire logic               OCO_TICK,
  input  wire logic               C32_TICK,
  // control strobes
  input  wire logic               START_WE,
  input  wire logic               START_VAL,
  input  wire logic               FORCE_STOP,
  input  wire logic               MODE_WE,
  input  wire ppot_pkg::ppot_wr_s WR,
  input  wire ppot_pkg::ppot_ioctl_s IOCTL,
  // port fallbacks and pin inputs
  input  wire logic               PORT_P1_7_OUT,
  input  wire logic               PORT_P1_5_OUT,
  input  wire logic               PORT_P3_0_OUT,
  input  wire logic               PORT_P3_7_OUT,
  input  wire logic               P1_7_IN,
  input  wire logic               P1_5_IN,
  // status
  output logic                    RUNNING,
  output logic [CNT_W-1:0]        PRE_COUNT,
  output logic [CNT_W-1:0]        TMR_COUNT,
  output logic                    IRQ,
  output logic                    EXT_INT_IN,
  // pins
  output logic                    P1_7_OUT,
  output logic                    P1_5_OUT,
  output logic                    P3_0_OUT,
  output logic                    P3_0_OE,
  output logic                    P3_7_OUT,
  output logic                    P3_7_OE
);
  ppot_pkg::ppot_state_e state;
  logic [CNT_W-1:0] pre_reload;
  logic [CNT_W-1:0] tmr_reload;
  logic             pulse;
  logic             tick;
  wire              run   = (state == ppot_pkg::PPOT_RUN);
  wire              cnt   = run && tick;
  wire              pre_uf = cnt && (PRE_COUNT == '0);
  wire              tmr_uf = pre_uf && (TMR_COUNT == '0);
  wire              pin_out = IOCTL.primary_stop ? 1'b0 : pulse;
  ppot_pkg::ppot_state_e next_state;
  logic             pre_pend;
  logic             tmr_pend;
  // write value widened to the counter width
  wire [CNT_W-1:0]  wr_val   = CNT_W'(WR.wdata);
  wire [CNT_W-1:0]  pre_load = WR.pre_we ? wr_val : pre_reload;
  wire [CNT_W-1:0]  tmr_load = WR.tmr_we ? wr_val : tmr_reload;
  // reload on underflow, on a pending write or on a write in the tick cycle
  wire              pre_take = cnt && (PRE_COUNT == '0 || pre_pend || WR.pre_we);
  wire              tmr_take = pre_uf && (TMR_COUNT == '0 || tmr_pend || WR.tmr_we);

  function automatic logic [CNT_W-1:0] dec1(input logic [CNT_W-1:0] v);
    return v - CNT_W'(1);
  endfunction : dec1

  ppot_src_sel u_src (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .SRC_SEL  (SRC_SEL),
    .OCO_TICK (OCO_TICK),
    .C32_TICK (C32_TICK),
    .TICK     (tick)
  );

  // start, stop and forced stop [R04] [R05]
  always_comb begin
    next_state = state;
    unique case (state)
      ppot_pkg::PPOT_IDLE: begin
        if (START_WE && START_VAL && !FORCE_STOP) next_state = ppot_pkg::PPOT_RUN;
      end
      ppot_pkg::PPOT_RUN: begin
        if (FORCE_STOP || (START_WE && !START_VAL)) next_state = ppot_pkg::PPOT_IDLE;
      end
      default: next_state = ppot_pkg::PPOT_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) state <= ppot_pkg::PPOT_IDLE;
    else        state <= next_state;
  end
  assign RUNNING = run;

  // reload registers take every write [R09] [R10]
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pre_reload <= `PPOT_PRE_RESET;
      tmr_reload <= `PPOT_TMR_RESET;
    end else begin
      if (WR.pre_we) pre_reload <= WR.wdata;
      if (WR.tmr_we) tmr_reload <= WR.wdata;
    end
  end

  // prescaler: stopped write loads directly, running reloads on tick [R09] [R11] [R12]
  always_ff @(posedge CLK) begin
    if (!RST_N) PRE_COUNT <= `PPOT_PRE_RESET;
    else if (WR.pre_we && !run) PRE_COUNT <= wr_val;
    else if (pre_take) PRE_COUNT <= pre_load; // [R02] [R03]
    else if (cnt) PRE_COUNT <= dec1(PRE_COUNT);
  end

  // running write waits for the next tick [R10] [R11]
  always_ff @(posedge CLK) begin
    if (!RST_N) pre_pend <= 1'b0;
    else if (WR.pre_we) pre_pend <= run && !cnt;
    else if (cnt) pre_pend <= 1'b0;
  end

  // timer counts prescaler underflows [R02] [R03] [R11] [R12]
  always_ff @(posedge CLK) begin
    if (!RST_N) TMR_COUNT <= `PPOT_TMR_RESET;
    else if (WR.tmr_we && !run) TMR_COUNT <= wr_val;
    else if (tmr_take) TMR_COUNT <= tmr_load;
    else if (pre_uf) TMR_COUNT <= dec1(TMR_COUNT);
  end

  // running write waits for the next prescaler underflow [R10] [R11]
  always_ff @(posedge CLK) begin
    if (!RST_N) tmr_pend <= 1'b0;
    else if (WR.tmr_we) tmr_pend <= run && !pre_uf;
    else if (pre_uf) tmr_pend <= 1'b0;
  end

  // pulse level: mode write sets start level, underflow toggles [R07] [R13] [R18] [R20]
  always_ff @(posedge CLK) begin
    if (!RST_N) pulse <= 1'b0;
    else if (MODE_WE) pulse <= IOCTL.start_level;
    else if (tmr_uf) pulse <= ~pulse;
  end

  // interrupt in underflow cycle [R06] [R20]
  assign IRQ = tmr_uf;

  // primary routing and port fallback [R16] [R17] [R19]
  assign P1_7_OUT   = IOCTL.primary_route ? PORT_P1_7_OUT : pin_out;
  assign P1_5_OUT   = IOCTL.primary_route ? pin_out : PORT_P1_5_OUT;
  assign EXT_INT_IN = IOCTL.primary_route ? P1_5_IN : P1_7_IN;

  // secondary inverse output and routing; primary stop leaves it pulsing [R14] [R15]
  assign P3_0_OUT = (IOCTL.secondary_en && !IOCTL.secondary_route) ? ~pulse : PORT_P3_0_OUT;
  assign P3_0_OE  = 1'b1;
  assign P3_7_OUT = (IOCTL.secondary_en && IOCTL.secondary_route) ? ~pulse : PORT_P3_7_OUT;
  assign P3_7_OE  = 1'b1;

  property p_irq_uf;
    @(posedge CLK) disable iff (!RST_N) IRQ |-> (TMR_COUNT == '0 && PRE_COUNT == '0 && run);
  endproperty
  a_irq_uf: assert property (p_irq_uf) else $error("irq without underflow"); // [R06]

  sequence s_underflow;
    tmr_uf && !MODE_WE;
  endsequence

  sequence s_toggled;
    pulse != $past(pulse);
  endsequence

  property p_toggle;
    @(posedge CLK) disable iff (!RST_N) s_underflow |=> s_toggled;
  endproperty
  a_toggle: assert property (p_toggle) else $error("pulse did not toggle"); // [R07]

  property p_reload;
    @(posedge CLK) disable iff (!RST_N)
      (tmr_uf && !WR.tmr_we) |=> (TMR_COUNT == $past(tmr_reload));
  endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded"); // [R02]

  property p_stopped_load;
    @(posedge CLK) disable iff (!RST_N) (WR.pre_we && !run) |=> (PRE_COUNT == $past(WR.wdata));
  endproperty
  a_stopped_load: assert property (p_stopped_load) else $error("stopped write lost"); // [R09]

  property p_hold_idle;
    @(posedge CLK) disable iff (!RST_N)
      (!run && !WR.pre_we && !WR.tmr_we) |=> ($stable(PRE_COUNT) && $stable(TMR_COUNT));
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("count while stopped"); // [R05]

  property p_start;
    @(posedge CLK) disable iff (!RST_N) (START_WE && START_VAL && !FORCE_STOP) |=> run;
  endproperty
  a_start: assert property (p_start) else $error("start ignored"); // [R04]

  property p_force;
    @(posedge CLK) disable iff (!RST_N) FORCE_STOP |=> !run;
  endproperty
  a_force: assert property (p_force) else $error("forced stop ignored"); // [R05]

  property p_mode;
    @(posedge CLK) disable iff (!RST_N) MODE_WE |=> (pulse == $past(IOCTL.start_level));
  endproperty
  a_mode: assert property (p_mode) else $error("start level not set"); // [R18]

  property p_inverse;
    @(posedge CLK) disable iff (!RST_N)
      (IOCTL.secondary_en && !IOCTL.secondary_route) |-> (P3_0_OUT == ~pulse);
  endproperty
  a_inverse: assert property (p_inverse) else $error("secondary not inverse"); // [R14]

  property p_pre_dec;
    @(posedge CLK) disable iff (!RST_N)
      (cnt && PRE_COUNT != '0 && !WR.pre_we && !pre_pend) |=>
      (PRE_COUNT == $past(PRE_COUNT) - 1'b1);
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("prescaler not decremented"); // [R12]

  property p_tmr_dec;
    @(posedge CLK) disable iff (!RST_N)
      (pre_uf && TMR_COUNT != '0 && !WR.tmr_we && !tmr_pend) |=>
      (TMR_COUNT == $past(TMR_COUNT) - 1'b1);
  endproperty
  a_tmr_dec: assert property (p_tmr_dec) else $error("timer not decremented"); // [R12]

  sequence s_run_pre_write;
    WR.pre_we && run && !cnt;
  endsequence

  sequence s_pre_kept;
    PRE_COUNT == $past(PRE_COUNT) && pre_pend;
  endsequence

  property p_run_write_held;
    @(posedge CLK) disable iff (!RST_N) s_run_pre_write |=> s_pre_kept;
  endproperty
  a_run_write_held: assert property (p_run_write_held) else $error("running write hit counter"); // [R10]

  property p_pre_pend_load;
    @(posedge CLK) disable iff (!RST_N)
      (cnt && pre_pend && !WR.pre_we) |=> (PRE_COUNT == $past(pre_reload));
  endproperty
  a_pre_pend_load: assert property (p_pre_pend_load) else $error("prescaler reload missed"); // [R11]

  property p_tmr_pend_load;
    @(posedge CLK) disable iff (!RST_N)
      (pre_uf && tmr_pend && !WR.tmr_we) |=> (TMR_COUNT == $past(tmr_reload));
  endproperty
  a_tmr_pend_load: assert property (p_tmr_pend_load) else $error("timer reload missed"); // [R11]

  property p_pre_uf_reload;
    @(posedge CLK) disable iff (!RST_N)
      (pre_uf && !WR.pre_we) |=> (PRE_COUNT == $past(pre_reload));
  endproperty
  a_pre_uf_reload: assert property (p_pre_uf_reload) else $error("prescaler not reloaded"); // [R02]

  property p_tmr_stopped_load;
    @(posedge CLK) disable iff (!RST_N)
      (WR.tmr_we && !run) |=> (TMR_COUNT == $past(wr_val));
  endproperty
  a_tmr_stopped_load: assert property (p_tmr_stopped_load) else $error("stopped timer write lost"); // [R09]

  property p_pre_reload_reg;
    @(posedge CLK) disable iff (!RST_N)
      WR.pre_we |=> (pre_reload == $past(wr_val));
  endproperty
  a_pre_reload_reg: assert property (p_pre_reload_reg) else $error("prescaler reload not written"); // [R10]

  property p_tmr_reload_reg;
    @(posedge CLK) disable iff (!RST_N)
      WR.tmr_we |=> (tmr_reload == $past(wr_val));
  endproperty
  a_tmr_reload_reg: assert property (p_tmr_reload_reg) else $error("timer reload not written"); // [R10]

  property p_stop;
    @(posedge CLK) disable iff (!RST_N)
      (START_WE && !START_VAL) |=> !run;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored"); // [R05]

  property p_irq_idle;
    @(posedge CLK) disable iff (!RST_N)
      !run |-> !IRQ;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq while stopped"); // [R06]

  property p_pulse_idle;
    @(posedge CLK) disable iff (!RST_N)
      (!run && !MODE_WE) |=> $stable(pulse);
  endproperty
  a_pulse_idle: assert property (p_pulse_idle) else $error("pulse moved while stopped"); // [R07]

  property p_stop_out;
    @(posedge CLK) disable iff (!RST_N)
      (IOCTL.primary_stop && !IOCTL.primary_route) |-> !P1_7_OUT;
  endproperty
  a_stop_out: assert property (p_stop_out) else $error("primary output not stopped"); // [R16]

  property p_route37;
    @(posedge CLK) disable iff (!RST_N)
      (IOCTL.secondary_en && IOCTL.secondary_route) |-> (P3_7_OUT == ~pulse);
  endproperty
  a_route37: assert property (p_route37) else $error("secondary not on alternate pin"); // [R15]

  property p_route15;
    @(posedge CLK) disable iff (!RST_N)
      IOCTL.primary_route |-> (P1_7_OUT == PORT_P1_7_OUT && P1_5_OUT == pin_out);
  endproperty
  a_route15: assert property (p_route15) else $error("primary not on alternate pin"); // [R17]

  property p_ext_sel;
    @(posedge CLK) disable iff (!RST_N)
      IOCTL.primary_route |-> (EXT_INT_IN == P1_5_IN);
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("interrupt input not routed"); // [R19]

  property p_f1_tick;
    @(posedge CLK) disable iff (!RST_N)
      (SRC_SEL == `PPOT_SRC_F1) |-> tick;
  endproperty
  a_f1_tick: assert property (p_f1_tick) else $error("undivided source lost"); // [R01]
endmodule : ppot_timer

// file: dv/ppot_pin_load.sv
// Purpose: far-side pin circuit of the pulse timer
// Assumes: pins read back the level the timer drives
// Notes:   alternate primary pin may be driven from outside
`timescale 1ns/1ns
module ppot_pin_load (
  // pins from the timer
  input  wire logic p1_7_out,
  input  wire logic p1_5_out,
  // outside drive
  input  wire logic ext_en,
  input  wire logic ext_lvl,
  // read-back
  output logic      p1_7_in,
  output logic      p1_5_in
);
  assign p1_7_in = p1_7_out;
  assign p1_5_in = ext_en ? ext_lvl : p1_5_out;
endmodule : ppot_pin_load

// file: dv/ppot_timer_tb.sv
// Purpose: random self-checking bench for the pulse output timer
// Assumes: divider sources modelled by a free-running count of eight
// Notes:   model compares every output at every edge
`timescale 1ns/1ns
module ppot_timer_tb;
  logic clk = 1'b0, rst_n = 1'b0, oco = 1'b0, c32 = 1'b0, st_we = 1'b0, st_val = 1'b0;
  logic fstop = 1'b0, mode_we = 1'b0, ext_en = 1'b0, ext_lvl = 1'b0;
  logic [2:0] src = 3'h0;
  logic [3:0] port = 4'h0;
  logic [15:0] lfsr = 16'h000D;
  ppot_pkg::ppot_wr_s wr = '0;
  ppot_pkg::ppot_ioctl_s ioc = '0;
  logic p17i, p15i, run, irq, ext, p17o, p15o, p30o, p30e, p37o, p37e;
  logic [7:0] pre_c, tmr_c;
  int errors = 0, compares = 0, cyc = 0, live = 0;
  int m_pre, m_tmr, m_prl, m_trl, m_run, m_pls, tick, uf, pin;
  int m_pp, m_tp, m_div, pu;
  logic [2:0] srcs [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};

  always #10 clk = ~clk;

  ppot_timer dut (.CLK(clk), .RST_N(rst_n), .SRC_SEL(src), .OCO_TICK(oco), .C32_TICK(c32),
    .START_WE(st_we), .START_VAL(st_val), .FORCE_STOP(fstop), .MODE_WE(mode_we), .WR(wr),
    .IOCTL(ioc), .PORT_P1_7_OUT(port[0]), .PORT_P1_5_OUT(port[1]), .PORT_P3_0_OUT(port[2]),
    .PORT_P3_7_OUT(port[3]), .P1_7_IN(p17i), .P1_5_IN(p15i), .RUNNING(run),
    .PRE_COUNT(pre_c), .TMR_COUNT(tmr_c), .IRQ(irq), .EXT_INT_IN(ext), .P1_7_OUT(p17o),
    .P1_5_OUT(p15o), .P3_0_OUT(p30o), .P3_0_OE(p30e), .P3_7_OUT(p37o), .P3_7_OE(p37e));

  ppot_pin_load load (.p1_7_out(p17o), .p1_5_out(p15o), .ext_en(ext_en), .ext_lvl(ext_lvl),
    .p1_7_in(p17i), .p1_5_in(p15i));

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  task automatic chk(input string nm, input int exp, input logic [7:0] got);
    compares++;
    if (got !== exp[7:0]) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp[7:0], got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // model: sees pre-edge inputs and outputs, then steps
  always @(posedge clk) begin
    tick = src == 3'h0 || (src == 3'h1 && m_div % 2 == 1) || (src == 3'h2 && m_div == 7) ||
      (src == 3'h4 && oco) || (src == 3'h6 && c32);
    pu = m_run && tick && m_pre == 0;
    uf = pu && m_tmr == 0;
    pin = ioc.primary_stop ? 0 : m_pls;
    if (live) begin
      chk("pre", m_pre, pre_c);
      chk("tmr", m_tmr, tmr_c);
      chk("run", m_run, run);
      chk("irq", uf, irq);
      chk("p17", ioc.primary_route ? port[0] : pin, p17o);
      chk("p15", ioc.primary_route ? pin : port[1], p15o);
      chk("p30", ioc.secondary_en && !ioc.secondary_route ? !m_pls : port[2], p30o);
      chk("p37", ioc.secondary_en && ioc.secondary_route ? !m_pls : port[3], p37o);
      chk("ext", ioc.primary_route ? p15i : p17i, ext);
      chk("p30e", 1, p30e);
      chk("p37e", 1, p37e);
    end
    if (!rst_n) begin
      m_pre = 255; m_tmr = 255; m_prl = 255; m_trl = 255; m_run = 0; m_pls = 0; live = 1;
      m_pp = 0;
      m_tp = 0;
      m_div = 0;
    end else begin
      if (m_run && tick) begin
        if (pu) begin
          if (m_tmr == 0 || m_tp || wr.tmr_we) m_tmr = wr.tmr_we ? wr.wdata : m_trl;
          else m_tmr = m_tmr - 1;
          m_tp = 0;
          if (uf) m_pls = !m_pls;
        end
        if (m_pre == 0 || m_pp || wr.pre_we) m_pre = wr.pre_we ? wr.wdata : m_prl;
        else m_pre = m_pre - 1;
        m_pp = 0;
      end
      if (wr.pre_we) begin
        m_prl = wr.wdata;
        m_pp = m_run && !tick;
        if (!m_run) m_pre = wr.wdata;
      end
      if (wr.tmr_we) begin
        m_trl = wr.wdata;
        m_tp = m_run && !pu;
        if (!m_run) m_tmr = wr.wdata;
      end
      m_div = (m_div + 1) % 8;
      if (fstop) m_run = 0;
      else if (st_we) m_run = st_val;
      if (mode_we) m_pls = ioc.start_level;
    end
  end

  // random stimulus, source changes every 700 cycles
  always @(posedge clk) begin
    lfsr <= lfsr_step(lfsr);
    cyc <= cyc + 1;
    rst_n <= !(cyc < 12 || (cyc >= 1500 && cyc < 1502));
    src <= srcs[(cyc / 700) % 5];
    oco <= lfsr[0];
    c32 <= lfsr[1] & lfsr[2];
    st_we <= lfsr[7:3] == 5'h00;
    st_val <= lfsr[8] | lfsr[9];
    fstop <= lfsr[15:10] == 6'h00;
    mode_we <= lfsr[14:11] == 4'h1;
    wr <= {lfsr[6:3] == 4'h3, lfsr[6:3] == 4'h5, 6'h00, lfsr[12:11]};
    if (lfsr[2:0] == 3'h0) ioc <= lfsr[15:11];
    port <= lfsr[9:6];
    ext_en <= lfsr[4];
    ext_lvl <= lfsr[5];
    if (cyc == 4200) report_and_stop();
  end

  initial begin
    #200000;
    errors = errors + 1;
    report_and_stop();
  end
endmodule : ppot_timer_tb
